// ==== src/phy_tx_pkg.sv ====
// shared constants and carrier types for the mac-side transmit port
package phy_tx_pkg;

  // ----------------------------------------------------------------
  // clock rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int TX100_HZ = 25_000_000;
  localparam int TX10_HZ = 2_500_000;
  localparam int SERIAL_HZ = 10_000_000;
  localparam int RMII_REF_HZ = 50_000_000;

  // ----------------------------------------------------------------
  // fractional divider: the phase accumulator wraps at DIV_DEN and
  // toggles the transmit clock once per wrap
  // ----------------------------------------------------------------
  localparam int DIV_UNIT_HZ = 100_000;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_DEN = DIV_W'(CLK_HZ / DIV_UNIT_HZ);

  // toggle step for a wanted output rate: two toggles per period
  function automatic logic [DIV_W-1:0] div_step(input int hz);
    div_step = DIV_W'(2 * (hz / DIV_UNIT_HZ));
  endfunction : div_step

  localparam logic [DIV_W-1:0] STEP_100 = div_step(TX100_HZ);
  localparam logic [DIV_W-1:0] STEP_10 = div_step(TX10_HZ);
  localparam logic [DIV_W-1:0] STEP_SERIAL = div_step(SERIAL_HZ);

  // ----------------------------------------------------------------
  // data unit widths per mode
  // ----------------------------------------------------------------
  localparam logic [2:0] BITS_NIBBLE = 3'h4;
  localparam logic [2:0] BITS_DIBIT = 3'h2;
  localparam logic [2:0] BITS_SERIAL = 3'h1;
  localparam logic [5:0] CFG_SETTLE = 6'h3F;

  typedef enum logic [1:0] {
    MODE_MII,
    MODE_RMII,
    MODE_SERIAL
  } tx_mode_t;

  // one captured transmit unit handed to the line side
  typedef struct packed {
    logic frame;
    logic valid;
    logic last;
    logic [2:0] bits;
    logic [3:0] data;
  } tx_unit_t;

endpackage : phy_tx_pkg

// ==== src/tx_clk_divider.sv ====
// fractional clock divider producing the device-sourced transmit clock
`timescale 1ns/10ps
module tx_clk_divider
  import phy_tx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic run_i,
  input wire logic [DIV_W-1:0] step_i,
  // generated clock and its edges
  output logic clk_o,
  output logic rise_o
);

  typedef struct packed {
    logic [DIV_W-1:0] acc;
    logic clk;
    logic rise;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;
  logic [DIV_W:0] sum;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    sum = {1'b0, st_r.acc} + {1'b0, step_i};
    if (!run_i) begin
      // parked low so the pin stays quiet in modes that do not use it
      st_nxt.acc = '0;
      st_nxt.clk = 1'b0;
    end else if (sum >= {1'b0, DIV_DEN}) begin
      st_nxt.acc = DIV_W'(sum - {1'b0, DIV_DEN});
      st_nxt.clk = ~st_r.clk;
      st_nxt.rise = ~st_r.clk;
    end else begin
      st_nxt.acc = DIV_W'(sum);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_o = st_r.clk;
  assign rise_o = st_r.rise;

endmodule : tx_clk_divider

// ==== src/phy_mac_transmit_port.sv ====
// transmit half of the mac-side data interface (nibble, dibit, serial)
//
// Behaviour
// - nibble mode drives transmit clock at 25 MHz or 2.5 MHz per speed.
// - dibit mode parks transmit clock; 50 MHz reference times the data.
// - serial mode drives transmit clock at 10 MHz.
// - nibble mode: enable high means a valid four-bit nibble is present.
// - dibit mode: enable high means a valid two-bit symbol on bits 1:0.
// - serial mode: enable high means valid data on the single bit.
// - nibble mode captures data on rising edges of our transmit clock.
// - dibit mode captures data on rising edges of the 50 MHz reference.
// - serial mode captures the data bit on our 10 MHz transmit clock.
`timescale 1ns/10ps
module phy_mac_transmit_port
  import phy_tx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // configuration, from logic on clk_i
  input wire tx_mode_t mode_i,
  input wire logic speed_100_i,
  // mac-side pins
  input wire logic ref_clock_in_i,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic tx_clk_o,
  // captured units toward the line side
  output tx_unit_t unit_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [3:0] d_s1;
    logic [3:0] d_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    tx_unit_t unit;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic div_run;
  logic [DIV_W-1:0] div_step_sel;
  logic div_rise;
  logic cap;

  // ----------------------------------------------------------------
  // transmit clock source
  // ----------------------------------------------------------------
  always_comb begin
    div_run = 1'b0;
    div_step_sel = STEP_100;
    unique case (mode_i)
      MODE_MII: begin
        div_run = 1'b1;
        div_step_sel = speed_100_i ? STEP_100 : STEP_10;
      end
      MODE_SERIAL: begin
        div_run = 1'b1;
        div_step_sel = STEP_SERIAL;
      end
      MODE_RMII: begin
        div_run = 1'b0;
      end
      default: begin
        div_run = 1'b0;
      end
    endcase
  end

  tx_clk_divider u_div (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(div_run),
    .step_i(div_step_sel),
    .clk_o(tx_clk_o),
    .rise_o(div_rise)
  );

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // pins and the reference clock go through matching two-stage synchronisers,
  // so a sample taken at a synchronised reference rise sees the unit the
  // controller launched on that same edge; at a divider rise it sees the unit launched one rise earlier
  always_comb begin
    st_nxt = st_r;
    st_nxt.en_s1 = tx_en_i;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.d_s1 = txd_i;
    st_nxt.d_s2 = st_r.d_s1;
    st_nxt.ref_s1 = ref_clock_in_i;
    st_nxt.ref_s2 = st_r.ref_s1;
    st_nxt.ref_s3 = st_r.ref_s2;
    st_nxt.unit.valid = 1'b0;
    st_nxt.unit.last = 1'b0;
    if (mode_i == MODE_RMII) begin
      cap = st_r.ref_s2 & ~st_r.ref_s3;
    end else begin
      cap = div_rise;
    end
    if (cap) begin
      if (st_r.en_s2) begin
        st_nxt.unit.frame = 1'b1;
        st_nxt.unit.valid = 1'b1;
        unique case (mode_i)
          MODE_RMII: begin
            st_nxt.unit.bits = BITS_DIBIT;
            st_nxt.unit.data = {2'h0, st_r.d_s2[1:0]};
          end
          MODE_SERIAL: begin
            st_nxt.unit.bits = BITS_SERIAL;
            st_nxt.unit.data = {3'h0, st_r.d_s2[0]};
          end
          default: begin
            st_nxt.unit.bits = BITS_NIBBLE;
            st_nxt.unit.data = st_r.d_s2;
          end
        endcase
      end else if (st_r.unit.frame) begin
        // enable low at a capture edge closes the frame
        st_nxt.unit.frame = 1'b0;
        st_nxt.unit.last = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign unit_o = st_r.unit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // config age counter: clock period checks only hold once a mode has settled; the dibit park check holds from age 3
  logic [5:0] cfg_age_r;
  tx_mode_t mode_d_r;
  logic speed_d_r;
  logic cfg_ok;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_age_r <= 6'h00;
      mode_d_r <= MODE_MII;
      speed_d_r <= 1'b0;
    end else begin
      mode_d_r <= mode_i;
      speed_d_r <= speed_100_i;
      if (mode_i != mode_d_r || speed_100_i != speed_d_r) begin
        cfg_age_r <= 6'h00;
      end else if (cfg_age_r != CFG_SETTLE) begin
        cfg_age_r <= cfg_age_r + 6'h01;
      end
    end
  end

  assign cfg_ok = (cfg_age_r == CFG_SETTLE);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_rise;
    $rose(tx_clk_o);
  endsequence

  // a rate change part way through a period is legal, so an attempt that
  // is still running when the configuration moves is dropped
  property p_mii100_period;
    disable iff (!rst_b_i || !cfg_ok)
    s_rise and (cfg_ok && mode_i == MODE_MII && speed_100_i)
      |-> ##1 (!$rose(tx_clk_o))[*4] ##1 s_rise;
  endproperty
  a_mii100_period: assert property (p_mii100_period)
    else $error("nibble 100M transmit clock period is not 5 cycles");

  property p_mii10_period;
    disable iff (!rst_b_i || !cfg_ok)
    s_rise and (cfg_ok && mode_i == MODE_MII && !speed_100_i)
      |-> ##50 s_rise;
  endproperty
  a_mii10_period: assert property (p_mii10_period)
    else $error("nibble 10M transmit clock period is not 50 cycles");

  property p_rmii_clk_parked;
    (mode_i == MODE_RMII && cfg_age_r > 6'h02) |-> !tx_clk_o;
  endproperty
  a_rmii_clk_parked: assert property (p_rmii_clk_parked)
    else $error("transmit clock toggles in dibit mode");

  property p_serial_period;
    disable iff (!rst_b_i || !cfg_ok)
    s_rise and (cfg_ok && mode_i == MODE_SERIAL)
      |-> ##[12:13] s_rise;
  endproperty
  a_serial_period: assert property (p_serial_period)
    else $error("serial transmit clock period is not 12 or 13 cycles");

  property p_nibble_capture;
    (mode_i == MODE_MII && $rose(tx_clk_o) && st_r.en_s2)
      |=> unit_o.valid && unit_o.bits == BITS_NIBBLE
          && unit_o.data == $past(st_r.d_s2);
  endproperty
  a_nibble_capture: assert property (p_nibble_capture)
    else $error("nibble not delivered after enabled clock edge");

  property p_dibit_capture;
    (mode_i == MODE_RMII && st_r.ref_s2 && !st_r.ref_s3 && st_r.en_s2)
      |=> unit_o.valid && unit_o.bits == BITS_DIBIT
          && unit_o.data[3:2] == 2'h0;
  endproperty
  a_dibit_capture: assert property (p_dibit_capture)
    else $error("dibit not delivered after enabled reference edge");

  property p_serial_capture;
    (mode_i == MODE_SERIAL && $rose(tx_clk_o) && st_r.en_s2)
      |=> unit_o.valid && unit_o.bits == BITS_SERIAL
          && unit_o.data == {3'h0, $past(st_r.d_s2[0])};
  endproperty
  a_serial_capture: assert property (p_serial_capture)
    else $error("serial bit not delivered after enabled clock edge");

  property p_nibble_on_clk;
    (unit_o.valid && mode_i == MODE_MII && mode_d_r == MODE_MII)
      |-> tx_clk_o && $past(tx_clk_o) && !$past(tx_clk_o, 2);
  endproperty
  a_nibble_on_clk: assert property (p_nibble_on_clk)
    else $error("nibble captured away from a transmit clock rise");

  property p_dibit_on_ref;
    (unit_o.valid && mode_i == MODE_RMII && mode_d_r == MODE_RMII)
      |-> $past(st_r.ref_s2) && !$past(st_r.ref_s3);
  endproperty
  a_dibit_on_ref: assert property (p_dibit_on_ref)
    else $error("dibit captured away from a reference rise");

  property p_serial_on_clk;
    (unit_o.valid && mode_i == MODE_SERIAL && mode_d_r == MODE_SERIAL)
      |-> tx_clk_o && $past(tx_clk_o) && !$past(tx_clk_o, 2);
  endproperty
  a_serial_on_clk: assert property (p_serial_on_clk)
    else $error("serial bit captured away from a transmit clock rise");

endmodule : phy_mac_transmit_port

// ==== tb/mac_model.sv ====
// behavioural media access controller driving the transmit pins
`timescale 1ns/10ps
module mac_model
  import phy_tx_pkg::*;
(
  // launch clock and control
  input wire logic launch_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [3:0] mask_i,
  // transmit pins
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  logic [7:0] sent_r;
  logic done_r;
  logic [3:0] pat;

  assign pat = sent_r[3:0] * 4'h3 + 4'h5;

  // ----------------------------------------------------------------
  // frame launch: one unit per launch edge, small clock-to-out delay
  // ----------------------------------------------------------------
  always @(posedge launch_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_en_o <= 1'b0;
      txd_o <= 4'h0;
      sent_r <= 8'h00;
      done_r <= 1'b0;
    end else if (!start_i) begin
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (sent_r < count_i) begin
        tx_en_o <= #1 1'b1;
        // unused lines held high so zero-extension is visible
        txd_o <= #1 (pat & mask_i) | ~mask_i;
        sent_r <= sent_r + 8'h01;
      end else begin
        tx_en_o <= #1 1'b0;
        // idle data lines do not keep the last unit
        txd_o <= #1 ~txd_o;
        sent_r <= 8'h00;
        done_r <= 1'b1;
      end
    end
  end
endmodule : mac_model

// ==== tb/testbench.sv ====
// self-checking bench for the mac-side transmit port
`timescale 1ns/10ps
module testbench;
  import phy_tx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ref_clock_in_i = 1'b0;
  logic speed_100_i = 1'b1;
  logic start = 1'b0;
  tx_mode_t mode_i = MODE_MII;
  logic [7:0] count = 8'h06;
  logic [3:0] mask = 4'hF;
  logic tx_en, tx_clk_o, launch;
  logic [3:0] txd;
  tx_unit_t unit_o;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_last = 0;
  logic [3:0] got_q[$];
  logic [2:0] bits_q[$];

  always #4 clk_i = ~clk_i;
  always #10 ref_clock_in_i = ~ref_clock_in_i;
  assign launch = (mode_i == MODE_RMII) ? ref_clock_in_i : tx_clk_o;

  phy_mac_transmit_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .mode_i(mode_i), .speed_100_i(speed_100_i),
    .ref_clock_in_i(ref_clock_in_i), .tx_en_i(tx_en), .txd_i(txd),
    .tx_clk_o(tx_clk_o), .unit_o(unit_o));
  mac_model mac (.launch_i(launch), .rst_b_i(rst_b_i), .start_i(start),
    .count_i(count), .mask_i(mask), .tx_en_o(tx_en), .txd_o(txd));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // outputs are registered, so sample them mid-cycle
  always @(negedge clk_i) begin
    cycles++;
    if (unit_o.valid === 1'b1) begin
      got_q.push_back(unit_o.data);
      bits_q.push_back(unit_o.bits);
      check(32'(unit_o.frame), 32'h1);
    end
    if (unit_o.last === 1'b1) n_last++;
    if (cycles > 30000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic set_mode(input tx_mode_t m, input logic s);
    @(posedge clk_i);
    #1;
    mode_i = m;
    speed_100_i = s;
    repeat (64) @(posedge clk_i);
    #1;
  endtask : set_mode

  task automatic measure(input int lo, input int hi);
    int n;
    int k;
    logic prev;
    n = 0;
    k = 0;
    prev = 1'b1;
    repeat (300) begin
      @(negedge clk_i);
      n++;
      if (tx_clk_o === 1'b1 && prev === 1'b0) begin
        if (k > 0 && k < 5) begin
          check(32'(n >= lo && n <= hi), 32'h1);
        end
        k++;
        n = 0;
      end
      prev = tx_clk_o;
    end
    check(32'(k > 4), 32'h1);
  endtask : measure

  task automatic send_frame(input logic [7:0] n, input logic [3:0] msk,
                            input logic [2:0] b);
    int w;
    int last0;
    logic [3:0] e;
    got_q.delete();
    bits_q.delete();
    last0 = n_last;
    @(posedge clk_i);
    #1;
    count = n;
    mask = msk;
    start = 1'b1;
    w = 0;
    while (n_last == last0 && w < 3000) begin
      @(posedge clk_i);
      w++;
    end
    #1;
    start = 1'b0;
    check(32'(got_q.size()), 32'(n));
    foreach (got_q[i]) begin
      e = 4'(i * 3 + 5) & msk;
      check(32'(got_q[i]), 32'(e));
      check(32'(bits_q[i]), 32'(b));
    end
    check(32'(n_last - last0), 32'h1);
  endtask : send_frame

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_mii100();
    set_mode(MODE_MII, 1'b1);
    measure(5, 5);
    send_frame(8'h14, 4'hF, BITS_NIBBLE);
    $display("test mii100 done");
  endtask : test_mii100

  task automatic test_mii10();
    set_mode(MODE_MII, 1'b0);
    measure(50, 50);
    send_frame(8'h05, 4'hF, BITS_NIBBLE);
    $display("test mii10 done");
  endtask : test_mii10

  task automatic test_serial();
    set_mode(MODE_SERIAL, 1'b1);
    measure(12, 13);
    send_frame(8'h10, 4'h1, BITS_SERIAL);
    $display("test serial done");
  endtask : test_serial

  task automatic test_rmii();
    int hi;
    // the unused code 3 must keep the transmit clock parked as well
    hi = 0;
    set_mode(tx_mode_t'(2'h3), 1'b1);
    repeat (100) begin
      @(negedge clk_i);
      if (tx_clk_o !== 1'b0) hi++;
    end
    set_mode(MODE_RMII, 1'b1);
    got_q.delete();
    repeat (200) begin
      @(negedge clk_i);
      if (tx_clk_o !== 1'b0) hi++;
    end
    check(32'(hi), 32'h0);
    check(32'(got_q.size()), 32'h0);
    send_frame(8'h0C, 4'h3, BITS_DIBIT);
    $display("test rmii done");
  endtask : test_rmii

  initial begin
    repeat (5) @(posedge clk_i);
    check(32'({unit_o, tx_clk_o}), 32'h0);
    #1;
    rst_b_i = 1'b1;
    test_mii100();
    test_mii10();
    test_serial();
    test_rmii();
    test_mii100();
    conclude();
  end
endmodule : testbench
